// *** rtl/sbo_defines.vh ***
`ifndef SBO_DEFINES_VH
`define SBO_DEFINES_VH
// Opcode prefixes (top three bits) for banked commands
`define SBO_PFX_BANKED_READ 3'h0
`define SBO_PFX_BANKED_WRITE 3'h2
`define SBO_PFX_BANKED_SET 3'h4
`define SBO_PFX_BANKED_CLEAR 3'h5
// Fixed unbanked opcodes
`define SBO_OP_FLAT_READ 8'h20
`define SBO_OP_FLAT_WRITE 8'h22
`define SBO_OP_FLAT_SET 8'h24
`define SBO_OP_FLAT_CLEAR 8'h26
// Register space
`define SBO_ADDR_W 8
`define SBO_BANK_SIZE 8'h20
`define SBO_FLAT_FIRST 8'h80
`define SBO_FLAT_LAST 8'h9f
`define SBO_REG_COUNT 160
// Media-access / management register range (lower byte even address)
`define SBO_MAC_FIRST 8'h40
`define SBO_MAC_LAST 8'h5f
// Buffer data windows, one-byte addresses of each window pair
`define SBO_WIN_GP 8'h7e
`define SBO_WIN_RX 8'h7f
`define SBO_WIN_UA 8'h1e
// Serial bit positions
`define SBO_BITS_PER_BYTE 4'h8
`endif

// *** rtl/sbo_sync3.v ***
// Three-stage pin synchroniser; output changes when stages two and three agree
module sbo_sync3 (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire pinIn,
   output reg pinOut
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // Stage one is read only by stage two
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         pinOut <= 1'b0;
      end
      else if (ce)
      begin
         s1_reg <= pinIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            pinOut <= s3_reg;
      end
   end
endmodule // sbo_sync3

// *** rtl/sbo_buf2.v ***
// Two-entry buffer with valid/ready on both sides
module sbo_buf2 #(
   parameter W = 16
) (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire inValid,
   output wire inReady,
   input wire [W-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [W-1:0] outData
);
   reg [W-1:0] mem_reg [0:1];
   reg rdPtr_reg;
   reg wrPtr_reg;
   reg [1:0] count_reg;
   wire push;
   wire pop;
   assign inReady = (count_reg != 2'h2);
   assign outValid = (count_reg != 2'h0);
   assign outData = mem_reg[rdPtr_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   // Pointers and occupancy
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdPtr_reg <= 1'b0;
         wrPtr_reg <= 1'b0;
         count_reg <= 2'h0;
         mem_reg[0] <= {W{1'b0}};
         mem_reg[1] <= {W{1'b0}};
      end
      else if (ce)
      begin
         if (push)
         begin
            mem_reg[wrPtr_reg] <= inData;
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (pop)
            rdPtr_reg <= ~rdPtr_reg;
         if (push && !pop)
            count_reg <= count_reg + 2'h1;
         else if (pop && !push)
            count_reg <= count_reg - 2'h1;
      end
   end
endmodule // sbo_buf2

// *** rtl/sbo_spi_cmd.v ***
// Contract
// - Banked set is 100+5-bit address, banked clear is 101+5-bit address.
// - Set: received mask is ORed into the addressed register. The code leaves media registers (40h-5Fh) unchanged.
// - Clear: addressed register is ANDed with inverted mask. The code leaves media registers (40h-5Fh) unchanged.
// - Set/clear use banked write timing and increment, one mask per register.
// - Unbanked: opcode, 8-bit absolute address, then data; read data ignored.
// - Unbanked commands never touch the stored bank selection.
// - Write and bit commands drive serial output while selected.
// - Unbanked read: filler on clocks 1-16, register bytes from clock 17, MSB first.
// - 16-bit words go lower byte first, then upper byte.
// - Unbanked address increments across banks, through 80h-9Fh, wraps to 00h.
// - Unbanked write opcode is 22h, address on clocks 9-16, then data.
// - Upper-byte-only media write stores upper byte, lower byte gets junk.
// - Select raised during media upper byte updates neither byte.
// - Unbanked writes to buffer windows change nothing, no pointer advance.
// - Banked read opcode is 000 plus 5-bit start address.
// - Banked write opcode is 010 plus 5-bit start address.
// - Banked address wraps to 00h of the same bank, bank unchanged.
// - Command runs until select rises; then serial output goes high impedance.
`include "sbo_defines.vh"
module sbo_spi_cmd #(
   parameter NREGS = `SBO_REG_COUNT
) (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire sck,
   input wire csn,
   input wire si,
   output wire so,
   output wire soOe,
   input wire [1:0] bankIn,
   input wire bankLoad,
   output wire [1:0] bankSel,
   output reg [7:0] wrAddr,
   output reg [7:0] wrData,
   output wire wrValid,
   input wire wrReady
);
   // Command states
   localparam ST_IDLE = 6'h01;
   localparam ST_OPC = 6'h02;
   localparam ST_ADDR = 6'h04;
   localparam ST_WRITE = 6'h08;
   localparam ST_READ = 6'h10;
   localparam ST_DROP = 6'h20;
   localparam OP_RD = 2'h0;
   localparam OP_WR = 2'h1;
   localparam OP_SET = 2'h2;
   localparam OP_CLR = 2'h3;

   reg rstS1_reg;
   reg rstS2_reg;
   wire srstn;
   wire sckS;
   wire csnS;
   wire siS;
   reg sckD_reg;
   reg [5:0] state_reg;
   reg [5:0] state_next;
   reg [2:0] bitCnt_reg;
   reg [7:0] shIn_reg;
   reg [7:0] shOut_reg;
   reg [7:0] addr_reg;
   reg [1:0] op_reg;
   reg banked_reg;
   reg [1:0] bank_reg;
   reg [7:0] regs [0:NREGS-1];
   reg [7:0] macHold_reg;
   reg macPend_reg;
   reg bufValid_reg;
   reg [15:0] bufData_reg;
   wire bufReady;
   wire outValid;
   wire [15:0] outData;
   wire sckRise;
   wire sckFall;
   wire [7:0] byteIn;
   wire byteDone;
   wire [7:0] nextAddr;
   wire isMac;
   wire isWindow;
   reg [7:0] curVal;
   reg [7:0] newVal;
   integer i;

   // Reset release through two flops
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstS1_reg <= 1'b0;
         rstS2_reg <= 1'b0;
      end
      else
      begin
         rstS1_reg <= 1'b1;
         rstS2_reg <= rstS1_reg;
      end
   end
   assign srstn = rstS2_reg;

   // All three pins settle to zero in reset, which reads as an idle, deselected bus
   sbo_sync3 uSck (
      .clk(clk),
      .rstn(srstn),
      .ce(ce),
      .pinIn(sck),
      .pinOut(sckS)
   );
   sbo_sync3 uCsn (
      .clk(clk),
      .rstn(srstn),
      .ce(ce),
      .pinIn(~csn),
      .pinOut(csnS)
   );
   sbo_sync3 uSi (
      .clk(clk),
      .rstn(srstn),
      .ce(ce),
      .pinIn(si),
      .pinOut(siS)
   );

   // csnS is high while selected (inverted before sync so reset means idle)
   assign sckRise = sckS && !sckD_reg;
   assign sckFall = !sckS && sckD_reg;
   assign byteIn = {shIn_reg[6:0], siS};
   assign byteDone = sckRise && (bitCnt_reg == 3'h7);
   assign isMac = (addr_reg >= `SBO_MAC_FIRST) && (addr_reg <= `SBO_MAC_LAST);
   assign isWindow = !banked_reg && ((addr_reg == `SBO_WIN_GP) || (addr_reg == `SBO_WIN_RX) ||
      (addr_reg == `SBO_WIN_UA));
   // Banked wraps within its bank; unbanked runs on to 9Fh then back to 00h
   assign nextAddr = banked_reg ? {addr_reg[7:5], addr_reg[4:0] + 5'h01} :
      ((addr_reg == `SBO_FLAT_LAST) ? 8'h00 : addr_reg + 8'h01);
   assign bankSel = bank_reg;
   // Output driven whole time selected, released once select rises
   assign soOe = csnS;
   assign so = shOut_reg[7];

   // Result of a data byte applied to its register's value; out-of-range addresses read as zero
   always @*
   begin
      curVal = (addr_reg < NREGS) ? regs[addr_reg] : 8'h00;
      case (op_reg)
         OP_SET: newVal = curVal | byteIn;
         OP_CLR: newVal = curVal & ~byteIn;
         default: newVal = byteIn;
      endcase
   end

   // Next-state decode of the command byte stream
   always @*
   begin
      state_next = state_reg;
      if (!csnS)
         state_next = ST_IDLE;
      else
         case (state_reg)
            ST_IDLE: state_next = ST_OPC;
            ST_OPC:
               if (byteDone)
               begin
                  case (byteIn[7:5])
                     `SBO_PFX_BANKED_READ: state_next = ST_READ;
                     `SBO_PFX_BANKED_WRITE, `SBO_PFX_BANKED_SET, `SBO_PFX_BANKED_CLEAR: state_next = ST_WRITE;
                     default: state_next = ST_DROP;
                  endcase
                  if ((byteIn == `SBO_OP_FLAT_READ) || (byteIn == `SBO_OP_FLAT_WRITE) ||
                     (byteIn == `SBO_OP_FLAT_SET) || (byteIn == `SBO_OP_FLAT_CLEAR))
                     state_next = ST_ADDR;
               end
            ST_ADDR: if (byteDone) state_next = (op_reg == OP_RD) ? ST_READ : ST_WRITE;
            ST_WRITE: state_next = ST_WRITE;
            ST_READ: state_next = ST_READ;
            ST_DROP: state_next = ST_DROP;
            default: state_next = ST_IDLE;
         endcase
   end

   // Serial engine: shift, decode, register updates
   always @(posedge clk or negedge srstn)
   begin
      if (!srstn)
      begin
         state_reg <= ST_IDLE;
         sckD_reg <= 1'b0;
         bitCnt_reg <= 3'h0;
         shIn_reg <= 8'h00;
         shOut_reg <= 8'h00;
         addr_reg <= 8'h00;
         op_reg <= OP_RD;
         banked_reg <= 1'b0;
         bank_reg <= 2'h0;
         macHold_reg <= 8'h00;
         macPend_reg <= 1'b0;
         bufValid_reg <= 1'b0;
         bufData_reg <= 16'h0000;
         for (i = 0; i < NREGS; i = i + 1)
            regs[i] <= 8'h00;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         sckD_reg <= sckS;
         if (bufValid_reg && bufReady)
            bufValid_reg <= 1'b0;
         if (bankLoad)
            bank_reg <= bankIn;
         if (!csnS)
         begin
            bitCnt_reg <= 3'h0;
            macPend_reg <= 1'b0;
         end
         else
         begin
            if (sckRise)
            begin
               shIn_reg <= byteIn;
               bitCnt_reg <= bitCnt_reg + 3'h1;
            end
            // No shift on the fall after a byte boundary: the freshly loaded MSB must stand for the next rise
            if (sckFall && bitCnt_reg != 3'h0)
               shOut_reg <= {shOut_reg[6:0], 1'b0};
            if (byteDone)
            begin
               case (state_reg)
                  ST_OPC:
                  begin
                     banked_reg <= 1'b1;
                     addr_reg <= {1'b0, bank_reg, byteIn[4:0]};
                     op_reg <= (byteIn[7:5] == `SBO_PFX_BANKED_READ) ? OP_RD :
                        (byteIn[7:5] == `SBO_PFX_BANKED_WRITE) ? OP_WR :
                        (byteIn[7:5] == `SBO_PFX_BANKED_SET) ? OP_SET : OP_CLR;
                     if (byteIn[7:5] == `SBO_PFX_BANKED_READ)
                        shOut_reg <= regs[{1'b0, bank_reg, byteIn[4:0]}];
                     if (byteIn[7:5] == 3'h1)
                     begin
                        banked_reg <= 1'b0;
                        op_reg <= byteIn[2:1];
                     end
                  end
                  ST_ADDR:
                  begin
                     addr_reg <= byteIn;
                     if (op_reg == OP_RD)
                        shOut_reg <= (byteIn < NREGS) ? regs[byteIn] : 8'h00;
                  end
                  ST_READ:
                  begin
                     addr_reg <= nextAddr;
                     shOut_reg <= (nextAddr < NREGS) ? regs[nextAddr] : 8'h00;
                  end
                  ST_WRITE:
                  begin
                     addr_reg <= nextAddr;
                     if (!isWindow && addr_reg < NREGS)
                        case (op_reg)
                           OP_SET: if (!isMac) regs[addr_reg] <= regs[addr_reg] | byteIn;
                           OP_CLR: if (!isMac) regs[addr_reg] <= regs[addr_reg] & ~byteIn;
                           default:
                              if (isMac && !addr_reg[0])
                              begin
                                 macHold_reg <= byteIn;
                                 macPend_reg <= 1'b1;
                              end
                              else if (isMac)
                              begin
                                 // Upper alone lands with a cleared low byte as its junk
                                 regs[addr_reg] <= byteIn;
                                 regs[{addr_reg[7:1], 1'b0}] <= macPend_reg ? macHold_reg : 8'h00;
                                 macPend_reg <= 1'b0;
                              end
                              else
                                 regs[addr_reg] <= byteIn;
                        endcase
                     // Log each byte's write, OR or AND-NOT result, except at buffer windows, so set and clear are visible downstream
                     if (!isWindow && addr_reg < NREGS)
                     begin
                        bufValid_reg <= 1'b1;
                        bufData_reg <= {addr_reg, newVal};
                     end
                  end
                  default: shOut_reg <= 8'h00;
               endcase
            end
         end
      end
   end

   // Write log towards the core; a stall here holds up to two words in the buffer
   sbo_buf2 #(.W(16)) uBuf (
      .clk(clk),
      .rstn(srstn),
      .ce(ce),
      .inValid(bufValid_reg),
      .inReady(bufReady),
      .inData(bufData_reg),
      .outValid(outValid),
      .outReady(wrReady),
      .outData(outData)
   );
   assign wrValid = outValid;
   always @*
   begin
      wrAddr = outData[15:8];
      wrData = outData[7:0];
   end
endmodule // sbo_spi_cmd

// *** verif/sbo_spi_cmd_assertions.sv ***
// Watches the serial command decoder from its ports only
module sbo_spi_cmd_assertions #(
   parameter NREGS = 160
) (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire sck,
   input wire csn,
   input wire si,
   input wire so,
   input wire soOe,
   input wire [1:0] bankIn,
   input wire bankLoad,
   input wire [1:0] bankSel,
   input wire [7:0] wrAddr,
   input wire [7:0] wrData,
   input wire wrValid,
   input wire wrReady
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Output enable tracks select once the pin synchroniser has settled
   property p_oe_on;
      (ce && !csn) [*8] |-> soOe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("soOe low inside a frame");
   property p_oe_off;
      (ce && csn) [*8] |-> !soOe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("soOe high while deselected");
   // A stalled log entry must not change under the receiver
   property p_valid_hold;
      wrValid && !wrReady |=> wrValid && $stable({wrAddr, wrData});
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("log entry changed while stalled");
   // Bank selection changes only by an explicit load
   property p_bank_load;
      bankLoad && ce |=> bankSel == $past(bankIn);
   endproperty
   a_bank_load: assert property (p_bank_load) else $error("bank load not taken");
   property p_bank_keep;
      !bankLoad |=> $stable(bankSel);
   endproperty
   a_bank_keep: assert property (p_bank_keep) else $error("bank selection moved");
   property p_addr_range;
      wrValid |-> wrAddr < NREGS;
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("write outside register space");
   // Once the frame has ended no new write may appear
   property p_idle_quiet;
      csn [*8] ##1 csn [*8] ##1 csn [*8] |-> !$rose(wrValid);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("write after frame end");
   property p_ce_freeze;
      !ce |=> $stable(bankSel) && $stable(wrValid) && $stable(soOe);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");
   c_take: cover property (wrValid && wrReady);
   c_stall: cover property (wrValid && !wrReady);
   c_load: cover property (bankLoad && ce);
endmodule // sbo_spi_cmd_assertions

// *** verif/sbo_host_model.sv ***
// Host acting as serial master; speed set by halfNs
module sbo_host_model (
   output logic sck,
   output logic csn,
   output logic si,
   input wire so,
   input wire soOe
);
   timeunit 1ns;
   timeprecision 100ps;
   int halfNs = 80;
   // Clock idles low and stands still between frames
   initial
   begin
      sck = 1'b0;
      csn = 1'b1;
      si = 1'b0;
   end
   // One command per select period
   task automatic frameOpen();
      csn = 1'b0;
      #(halfNs);
   endtask
   // Most significant bit first; data changes only while the clock is low
   task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nBits; i--)
      begin
         si = tx[i];
         #(halfNs);
         sck = 1'b1;
         rx[i] = so;
         #(halfNs);
         sck = 1'b0;
      end
   endtask
   // Hold time lets the last write land; released data line is not left at its last value
   task automatic frameClose();
      #(2 * halfNs);
      csn = 1'b1;
      si = ~si;
      #(4 * halfNs);
   endtask
endmodule // sbo_host_model

// *** verif/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rstn, ce, bankLoad, wrReady;
   logic [1:0] bankIn;
   wire sck, csn, si, so, soOe, wrValid;
   wire [1:0] bankSel;
   wire [7:0] wrAddr, wrData;
   logic [15:0] seedReg = 16'h6dc3;
   logic [7:0] sh [0:255];
   logic [15:0] expQ[$], gotQ[$];
   logic [7:0] rxQ[$];
   int num_errors = 0;
   int total_checks = 0;
   sbo_spi_cmd #(.NREGS(160)) sbo_spi_cmd_inst (.clk(clk), .rstn(rstn), .ce(ce), .sck(sck), .csn(csn), .si(si),
      .so(so), .soOe(soOe), .bankIn(bankIn), .bankLoad(bankLoad), .bankSel(bankSel), .wrAddr(wrAddr),
      .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady));
   sbo_host_model sbo_host_model_inst (.sck(sck), .csn(csn), .si(si), .so(so), .soOe(soOe));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [7:0] rnd();
      seedReg = {seedReg[14:0], seedReg[15] ^ seedReg[13] ^ seedReg[12] ^ seedReg[10]};
      return seedReg[7:0];
   endfunction
   function automatic logic [7:0] nextAddr(input logic [7:0] a, input bit flat);
      if (flat)
         return (a == 8'h9f) ? 8'h00 : a + 8'h01;
      return {a[7:5], a[4:0] + 5'h01};
   endfunction
   // Receiver stalls at random so log entries wait in the two-entry buffer
   always @(negedge clk)
      wrReady <= rnd() < 8'h60;
   always @(posedge clk)
      if (wrValid === 1'b1 && wrReady === 1'b1)
         gotQ.push_back({wrAddr, wrData});
   task automatic chkLog(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      chkLog(what, {8'h00, exp}, {8'h00, got});
   endtask
   task automatic send(input logic [7:0] b[$]);
      logic [7:0] r;
      rxQ.delete();
      sbo_host_model_inst.frameOpen();
      foreach (b[i])
      begin
         sbo_host_model_inst.xfer(b[i], 8, r);
         rxQ.push_back(r);
      end
      sbo_host_model_inst.frameClose();
   endtask
   // Kind 0 write, 1 set, 2 clear; predicts the log it must cause
   task automatic wr(input int kind, input bit flat, input logic [7:0] a, input int n);
      logic [7:0] b[$];
      logic [7:0] m;
      b.push_back(flat ? 8'h22 + 8'(2 * kind) : {kind == 0 ? 3'h2 : 3'(3 + kind), a[4:0]});
      if (flat)
         b.push_back(a);
      repeat (n)
      begin
         m = rnd();
         b.push_back(m);
         // Windows keep their contents, so the model skips them too
         if (!(flat && (a == 8'h7e || a == 8'h7f || a == 8'h1e)))
         begin
            sh[a] = kind == 0 ? m : kind == 1 ? sh[a] | m : sh[a] & ~m;
            expQ.push_back({a, sh[a]});
         end
         a = nextAddr(a, flat);
      end
      send(b);
   endtask
   task automatic drain(input string name);
      int n;
      n = 0;
      while (gotQ.size() < expQ.size() && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      repeat (40) @(posedge clk);
      chkByte("log count", 8'(expQ.size()), 8'(gotQ.size()));
      while (expQ.size() > 0 && gotQ.size() > 0)
         chkLog(name, expQ.pop_front(), gotQ.pop_front());
      expQ.delete();
      gotQ.delete();
      $display("test %s done", name);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #500000;
      num_errors++;
      end_sim();
   end
   // Main sequence: bank load, bit operations, wraps, windows, media words, reads, random traffic
   initial
   begin
      logic [7:0] r;
      logic [7:0] m;
      foreach (sh[i])
         sh[i] = 8'h00;
      rstn = 1'b0;
      ce = 1'b1;
      bankLoad = 1'b0;
      bankIn = 2'h1;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      bankLoad = 1'b1;
      @(negedge clk);
      bankLoad = 1'b0;
      repeat (3) @(negedge clk);
      chkByte("bankSel", 8'h01, {6'h00, bankSel});
      for (int k = 0; k < 3; k++)
      begin
         wr(k, 1'b0, 8'h3f, 2);
         wr(k, 1'b1, 8'h0f, 2);
         drain("bitops");
      end
      wr(0, 1'b1, 8'h9e, 3);
      wr(0, 1'b1, 8'h7e, 3);
      drain("flat wrap");
      chkByte("bankSel kept", 8'h01, {6'h00, bankSel});
      wr(0, 1'b1, 8'h40, 2);
      drain("media pair");
      m = rnd();
      expQ.push_back({8'h40, m});
      sbo_host_model_inst.frameOpen();
      sbo_host_model_inst.xfer(8'h22, 8, r);
      sbo_host_model_inst.xfer(8'h40, 8, r);
      sbo_host_model_inst.xfer(m, 8, r);
      sbo_host_model_inst.xfer(rnd(), 4, r);
      sbo_host_model_inst.frameClose();
      drain("media abort");
      send('{8'h20, 8'h40, rnd(), rnd()});
      chkByte("media low kept", sh[8'h40], rxQ[2]);
      chkByte("media high kept", sh[8'h41], rxQ[3]);
      send('{8'h20, 8'h0f, rnd(), rnd()});
      chkByte("flat read low", sh[8'h0f], rxQ[2]);
      chkByte("flat read high", sh[8'h10], rxQ[3]);
      send('{8'h1f, rnd(), rnd()});
      chkByte("banked read", sh[8'h3f], rxQ[1]);
      chkByte("banked read wrap", sh[8'h20], rxQ[2]);
      send('{8'h20, 8'h7e, rnd(), rnd(), rnd()});
      chkByte("window 7e kept", sh[8'h7e], rxQ[2]);
      chkByte("window 7f kept", sh[8'h7f], rxQ[3]);
      chkByte("after window", sh[8'h80], rxQ[4]);
      $display("test reads done");
      @(negedge clk);
      ce = 1'b0;
      repeat (3) @(negedge clk);
      ce = 1'b1;
      sbo_host_model_inst.halfNs = 200;
      repeat (6)
      begin
         r = rnd();
         wr(0, r[0], r[0] ? {3'h0, r[5:1]} : {3'h1, r[5:1]}, 1 + r[7:6]);
         drain("random");
      end
      end_sim();
   end
endmodule // tb_top
bind sbo_spi_cmd sbo_spi_cmd_assertions #(.NREGS(NREGS)) sbo_spi_cmd_assertions_inst (.clk(clk), .rstn(rstn),
   .ce(ce), .sck(sck), .csn(csn), .si(si), .so(so), .soOe(soOe), .bankIn(bankIn), .bankLoad(bankLoad),
   .bankSel(bankSel), .wrAddr(wrAddr), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady));
